// >>> bench/pcbh_chk.sv
// Concurrent checks on the shared wires of the control handshake.
`timescale 1ns/1ps
`include "pcbh_map.svh"
module pcbh_chk (
  input wire logic i_clk, i_reset, frame_n, irdy_n, devsel_n, trdy_n, stop_n, par, idsel,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic dev_ictl_oe, dev_tctl_oe, dev_ad_oe, dev_par_oe, dev_req_n, dev_serr_oe,
  input wire logic dev_perr_oe, peer_ictl_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_peer_addr;
    $fell(frame_n) && peer_ictl_oe;
  endsequence
  sequence s_no_sel;
    devsel_n [*8];
  endsequence
  property p_rst;
    disable iff (1'b0) i_reset |=> !dev_ictl_oe && !dev_tctl_oe && !dev_ad_oe && !dev_par_oe
      && dev_req_n && !dev_serr_oe && !dev_perr_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active in reset");
  property p_claim;
    s_peer_addr ##0 (cbe == `PCBH_CMD_MEMRD || cbe == `PCBH_CMD_MEMWR)
      && ((ad & `PCBH_DEV_MASK) == `PCBH_DEV_BASE) |=> !devsel_n && dev_tctl_oe;
  endproperty
  a_claim: assert property (p_claim) else $error("own cycle not claimed");
  property p_cfg;
    s_peer_addr ##0 cbe[3:1] == 3'h5 |=> devsel_n == !$past(idsel);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config claim wrong");
  property p_abt;
    dev_ictl_oe && $fell(frame_n) ##1 s_no_sel |-> frame_n;
  endproperty
  a_abt: assert property (p_abt) else $error("unclaimed cycle not ended");
  property p_frm;
    $rose(frame_n) && dev_ictl_oe |-> !irdy_n;
  endproperty
  a_frm: assert property (p_frm) else $error("frame ended outside last phase");
  property p_wait;
    dev_ictl_oe && !irdy_n && trdy_n && stop_n && !devsel_n |=> !irdy_n && dev_ictl_oe;
  endproperty
  a_wait: assert property (p_wait) else $error("ready dropped in wait");
  property p_fin;
    dev_tctl_oe && !devsel_n && !trdy_n && !irdy_n && frame_n |=> devsel_n && trdy_n
      ##1 !dev_tctl_oe;
  endproperty
  a_fin: assert property (p_fin) else $error("target end wrong");
  property p_stop;
    dev_ictl_oe && !stop_n && !devsel_n |=> frame_n;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_par;
    dev_ad_oe |=> dev_par_oe && par == ^{$past(ad), $past(cbe)};
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  property p_serr;
    dev_serr_oe |=> !dev_serr_oe;
  endproperty
  a_serr: assert property (p_serr) else $error("system error not a pulse");
endmodule

// >>> bench/test_pci_bus_control_handshake.sv
// Bench joining both ends on the shared bus and running transfers through tasks.
`timescale 1ns/1ps
module test_pci_bus_control_handshake;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic d_start = 1'b0, d_write = 1'b0, d_disc = 1'b0, d_cben = 1'b0, d_cbperr = 1'b0;
  logic d_syserr = 1'b0, p_park = 1'b0, p_start = 1'b0, p_write = 1'b0, p_cfg = 1'b0;
  logic p_wait = 1'b0, p_stop = 1'b0;
  logic [31:0] d_addr = 32'h0, d_wdata = 32'h0, p_addr = 32'h0, p_wdata = 32'h0;
  logic [7:0] d_beats = 8'h1;
  logic [15:0] d_cmd = 16'h0140;
  logic d_busy, d_done, d_abort, d_rvalid, d_twvalid, d_perr, p_busy, p_done, p_rvalid;
  logic [31:0] d_rdata, d_twdata, p_rdata, p_mem, got;
  logic got_abort, saw_req, saw_tw;
  int n_errors = 0;
  int num_checks = 0;
  pcbh_if bus ();
  pcbh_dev i_pcbh_dev (.i_clk(clk), .i_reset(rst), .bus(bus), .i_start(d_start),
    .i_write(d_write), .i_cfg(1'b0), .i_addr(d_addr), .i_wdata(d_wdata), .i_be_n(4'h0),
    .i_beats(d_beats), .o_busy(d_busy), .o_done(d_done), .o_abort(d_abort),
    .o_rvalid(d_rvalid), .o_rdata(d_rdata), .i_disconnect(d_disc), .o_twvalid(d_twvalid),
    .o_twdata(d_twdata), .i_command(d_cmd), .i_cb_serr_en(d_cben), .i_cb_addr_perr(d_cbperr),
    .i_sys_err(d_syserr), .o_perr_seen(d_perr));
  pcbh_peer i_pcbh_peer (.i_clk(clk), .i_reset(rst), .bus(bus), .i_park(p_park),
    .i_start(p_start), .i_write(p_write), .i_cfg(p_cfg), .i_addr(p_addr), .i_wdata(p_wdata),
    .o_busy(p_busy), .o_done(p_done), .o_abort(), .o_rvalid(p_rvalid), .o_rdata(p_rdata),
    .i_wait(p_wait), .i_stop(p_stop), .o_wvalid(), .o_wdata(p_mem));
  pcbh_chk i_pcbh_chk (.i_clk(clk), .i_reset(rst), .frame_n(bus.frame_n),
    .irdy_n(bus.irdy_n), .devsel_n(bus.devsel_n), .trdy_n(bus.trdy_n), .stop_n(bus.stop_n),
    .par(bus.par), .idsel(bus.idsel), .ad(bus.ad), .cbe(bus.cbe),
    .dev_ictl_oe(bus.dev_ictl_oe), .dev_tctl_oe(bus.dev_tctl_oe), .dev_ad_oe(bus.dev_ad_oe),
    .dev_par_oe(bus.dev_par_oe), .dev_req_n(bus.dev_req_n), .dev_serr_oe(bus.dev_serr_oe),
    .dev_perr_oe(bus.dev_perr_oe), .peer_ictl_oe(bus.peer_ictl_oe));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_idle(input bit late);
    int k;
    for (k = 0; k < 30 && (d_busy !== 1'b0 || p_busy !== 1'b0); k++) @(negedge clk);
    if (late || k == 30) begin
      chk(1'b0, 1'b1);
      test_done();
    end
  endtask
  task automatic dev_run(input logic w, input logic [31:0] a, input logic [7:0] n);
    int k;
    got = 32'h0;
    saw_req = 1'b0;
    @(posedge clk);
    d_write <= w;
    d_addr <= a;
    d_wdata <= 32'ha5a5_0f0f;
    d_beats <= n;
    d_start <= 1'b1;
    @(posedge clk);
    d_start <= 1'b0;
    for (k = 0; k < 60 && d_done !== 1'b1 && d_abort !== 1'b1; k++) begin
      @(negedge clk);
      if (bus.req_n === 1'b0) saw_req = 1'b1;
      if (d_rvalid === 1'b1) got = d_rdata;
    end
    got_abort = d_abort;
    wait_idle(k == 60);
  endtask
  task automatic peer_run(input logic w, input logic c, input logic [31:0] a);
    int k;
    bit late;
    got = 32'h0;
    saw_tw = 1'b0;
    @(posedge clk);
    p_write <= w;
    p_cfg <= c;
    p_addr <= a;
    p_wdata <= c ? 32'h0f1e_2d3c : 32'h3c3c_5a5a;
    p_start <= 1'b1;
    for (k = 0; k < 30 && p_busy !== 1'b1; k++) @(negedge clk);
    late = (k == 30);
    @(posedge clk);
    p_start <= 1'b0;
    for (k = 0; k < 30 && p_done !== 1'b1; k++) begin
      @(negedge clk);
      if (p_rvalid === 1'b1) got = p_rdata;
      if (d_twvalid === 1'b1) saw_tw = 1'b1;
    end
    wait_idle(late || k == 30);
    chk({d_perr, bus.perr_n}, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({bus.req_n, bus.serr_n, bus.frame_n, bus.devsel_n}, 32'hf);
    @(posedge clk);
    p_park <= 1'b1;
    dev_run(1'b1, 32'h2000_0010, 8'h1);
    chk(p_mem, 32'ha5a5_0f0f);
    chk(saw_req, 1'b0);
    p_wait <= 1'b1;
    fork
      dev_run(1'b0, 32'h2000_0010, 8'h1);
      begin
        repeat (6) @(posedge clk);
        p_wait <= 1'b0;
      end
    join
    chk(got, 32'ha5a5_0f0f);
    p_park <= 1'b0;
    dev_run(1'b0, 32'h3000_0000, 8'h1);
    chk(got_abort, 1'b1);
    chk(saw_req, 1'b1);
    p_stop <= 1'b1;
    dev_run(1'b0, 32'h2000_0010, 8'h4);
    chk(got_abort, 1'b0);
    p_stop <= 1'b0;
    peer_run(1'b1, 1'b0, 32'h1000_0020);
    chk(d_twdata, 32'h3c3c_5a5a);
    chk(saw_tw, 1'b1);
    peer_run(1'b0, 1'b0, 32'h1000_0020);
    chk(got, 32'h3c3c_5a5a);
    d_disc <= 1'b1;
    peer_run(1'b0, 1'b0, 32'h1000_0020);
    chk(got, 32'h3c3c_5a5a);
    d_disc <= 1'b0;
    peer_run(1'b1, 1'b1, 32'h0000_0000);
    chk(saw_tw, 1'b0);
    chk(d_twdata, 32'h3c3c_5a5a);
    peer_run(1'b0, 1'b1, 32'h0000_0000);
    chk(got, 32'h0f1e_2d3c);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      d_cmd <= (i == 0) ? 16'h0140 : 16'h0040;
      d_cben <= (i == 2);
      @(posedge clk);
      d_syserr <= (i < 2);
      d_cbperr <= (i >= 2);
      @(posedge clk);
      d_syserr <= 1'b0;
      d_cbperr <= 1'b0;
      @(negedge clk);
      chk(bus.serr_n, i[0]);
    end
    test_done();
  end
endmodule

// >>> hw/pcbh_dev.sv
// Device end of the control handshake: initiator, target, parity and error signalling.
//
// Notes on behaviour
// - Target claims its cycles by asserting device select.
// - Initiator aborts when no device select before timeout.
// - Frame held until final data phase reached.
// - Parked grant accepted; start only on idle bus.
// - Configuration cycles answered only with IDSEL asserted.
// - Data transferred only with both readies; target stop or initiator abort also ends the phase.
// - Initiator ready means it can complete phase.
// - Target ready means it can complete phase.
// - Parity error driven only when command bit 6 set.
// - Request asserted while a transaction waits for bus.
// - System error pulse only when reporting enabled.
// - System error pulse also when not the target.
// - Card-side address parity error pulses system error.
// - Target stop makes the initiator end transaction.
// - Even parity driven one clock after covered data.
// - Target compares received parity and flags mismatch.
`timescale 1ns/1ps
`include "pcbh_map.svh"
module pcbh_dev #(
  parameter logic [31:0] BASE = `PCBH_DEV_BASE,
  parameter logic [31:0] MASK = `PCBH_DEV_MASK,
  parameter logic [3:0] TIMEOUT = `PCBH_DEVSEL_TMO
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Bus side.
  pcbh_if.dev_mp bus,
  // Initiator requests.
  input wire logic i_start,
  input wire logic i_write,
  input wire logic i_cfg,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_be_n,
  input wire logic [7:0] i_beats,
  // Initiator answers.
  output logic o_busy,
  output logic o_done,
  output logic o_abort,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  // Target side.
  input wire logic i_disconnect,
  output logic o_twvalid,
  output logic [31:0] o_twdata,
  // Error reporting.
  input wire logic [15:0] i_command,
  input wire logic i_cb_serr_en,
  input wire logic i_cb_addr_perr,
  input wire logic i_sys_err,
  output logic o_perr_seen
);
  localparam pcbh_pkg::pcbh_dev_st_t RST = '{
    ist: pcbh_pkg::pcbh_i_idle,
    tst: pcbh_pkg::pcbh_t_idle,
    req_n: 1'b1,
    frame_n: 1'b1,
    irdy_n: 1'b1,
    devsel_n: 1'b1,
    trdy_n: 1'b1,
    stop_n: 1'b1,
    perr_n: 1'b1,
    frame_prev_n: 1'b1,
    default: '0
  };
  pcbh_pkg::pcbh_dev_st_t st, next_st;
  logic idle_bus, addr_phase, hit, launch, ixfer, txfer, mism, timeout, is_cfg, is_mem;
  logic [3:0] cmd_in;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.abort = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.twvalid = 1'b0;
    next_st.perr_seen = 1'b0;
    next_st.perr_n = 1'b1;
    next_st.perr_oe = ~st.perr_n;
    idle_bus = bus.frame_n & bus.irdy_n;
    ixfer = ~st.irdy_n & ~bus.trdy_n;
    txfer = ~bus.irdy_n & ~st.trdy_n;
    addr_phase = ~bus.frame_n & st.frame_prev_n & (st.ist != pcbh_pkg::pcbh_i_addr);
    is_cfg = (bus.cbe == `PCBH_CMD_CFGRD) | (bus.cbe == `PCBH_CMD_CFGWR);
    is_mem = (bus.cbe == `PCBH_CMD_MEMRD) | (bus.cbe == `PCBH_CMD_MEMWR);
    hit = (is_cfg & bus.idsel) | (is_mem & ((bus.ad & MASK) == BASE));
    cmd_in = i_cfg ? (i_write ? `PCBH_CMD_CFGWR : `PCBH_CMD_CFGRD)
                   : (i_write ? `PCBH_CMD_MEMWR : `PCBH_CMD_MEMRD);
    launch = ~bus.gnt_n & idle_bus & (st.tst == pcbh_pkg::pcbh_t_idle) &
             (((st.ist == pcbh_pkg::pcbh_i_idle) & i_start) | (st.ist == pcbh_pkg::pcbh_i_req));
    timeout = ~st.got_dev & bus.devsel_n & (st.tcnt == TIMEOUT - 4'h1);
    mism = bus.par != st.par;
    case (st.ist)
      pcbh_pkg::pcbh_i_idle: begin
        if (i_start) begin
          next_st.icmd = cmd_in;
          next_st.iaddr = i_addr;
          next_st.iwdata = i_wdata;
          next_st.ibe = i_be_n;
          next_st.remain = i_beats;
          next_st.busy = 1'b1;
          next_st.req_n = 1'b0;
          next_st.ist = pcbh_pkg::pcbh_i_req;
        end
      end
      pcbh_pkg::pcbh_i_req: begin
        next_st.req_n = 1'b0;
      end
      pcbh_pkg::pcbh_i_addr: begin
        next_st.ist = pcbh_pkg::pcbh_i_data;
        next_st.irdy_n = 1'b0;
        next_st.frame_n = st.remain <= 8'h1;
        next_st.ad = st.iwdata;
        next_st.ad_oe = st.icmd[0];
        next_st.cbe = st.ibe;
        next_st.tcnt = 4'h0;
        next_st.got_dev = 1'b0;
        next_st.abort_pend = 1'b0;
      end
      pcbh_pkg::pcbh_i_data: begin
        if (~bus.devsel_n) begin
          next_st.got_dev = 1'b1;
        end else if (~st.got_dev) begin
          next_st.tcnt = st.tcnt + 4'h1;
        end
        if (timeout) begin
          next_st.abort_pend = 1'b1;
        end
        if (ixfer) begin
          next_st.remain = st.remain - 8'h1;
          next_st.rvalid = ~st.icmd[0];
          next_st.rdata = bus.ad;
        end
        if (st.frame_n) begin
          if (ixfer | ~bus.stop_n | st.abort_pend) begin
            next_st.ist = pcbh_pkg::pcbh_i_turn;
            next_st.irdy_n = 1'b1;
            next_st.ad_oe = 1'b0;
            next_st.cbe_oe = 1'b0;
            next_st.done = ~st.abort_pend;
            next_st.abort = st.abort_pend;
          end
        end else if (~bus.stop_n | timeout | (ixfer & (st.remain == 8'h2))) begin
          next_st.frame_n = 1'b1;
        end
      end
      pcbh_pkg::pcbh_i_turn: begin
        next_st.ictl_oe = 1'b0;
        next_st.busy = 1'b0;
        next_st.ist = pcbh_pkg::pcbh_i_idle;
      end
      default: begin
        next_st.ist = pcbh_pkg::pcbh_i_idle;
      end
    endcase
    if (launch) begin
      next_st.ist = pcbh_pkg::pcbh_i_addr;
      next_st.req_n = 1'b1;
      next_st.frame_n = 1'b0;
      next_st.irdy_n = 1'b1;
      next_st.ictl_oe = 1'b1;
      next_st.ad = (st.ist == pcbh_pkg::pcbh_i_idle) ? i_addr : st.iaddr;
      next_st.cbe = (st.ist == pcbh_pkg::pcbh_i_idle) ? cmd_in : st.icmd;
      next_st.ad_oe = 1'b1;
      next_st.cbe_oe = 1'b1;
    end
    case (st.tst)
      pcbh_pkg::pcbh_t_idle: begin
        if (addr_phase & hit) begin
          next_st.tst = pcbh_pkg::pcbh_t_claim;
          next_st.devsel_n = 1'b0;
          next_st.trdy_n = 1'b1;
          next_st.stop_n = 1'b1;
          next_st.tctl_oe = 1'b1;
          next_st.t_write = bus.cbe[0];
          next_st.t_cfg = is_cfg;
        end
      end
      pcbh_pkg::pcbh_t_claim: begin
        next_st.tst = pcbh_pkg::pcbh_t_data;
        next_st.trdy_n = 1'b0;
        next_st.stop_n = ~i_disconnect;
        if (~st.t_write) begin
          next_st.ad = st.t_cfg ? st.cfgreg : st.memreg;
          next_st.ad_oe = 1'b1;
        end
      end
      pcbh_pkg::pcbh_t_data: begin
        if (txfer & st.t_write) begin
          if (st.t_cfg) begin
            next_st.cfgreg = bus.ad;
          end else begin
            next_st.memreg = bus.ad;
            next_st.twvalid = 1'b1;
          end
        end
        if (bus.frame_n & (txfer | ~st.stop_n)) begin
          next_st.tst = pcbh_pkg::pcbh_t_turn;
          next_st.devsel_n = 1'b1;
          next_st.trdy_n = 1'b1;
          next_st.stop_n = 1'b1;
          next_st.ad_oe = 1'b0;
        end else if (txfer & ~st.stop_n) begin
          next_st.trdy_n = 1'b1;
        end
      end
      pcbh_pkg::pcbh_t_turn: begin
        next_st.tctl_oe = 1'b0;
        next_st.tst = pcbh_pkg::pcbh_t_idle;
      end
      default: begin
        next_st.tst = pcbh_pkg::pcbh_t_idle;
      end
    endcase
    next_st.frame_prev_n = bus.frame_n;
    next_st.par = pcbh_pkg::pcbh_parity(bus.ad, bus.cbe);
    next_st.par_oe = st.ad_oe;
    next_st.chk_addr = addr_phase;
    next_st.chk_data = (st.tst == pcbh_pkg::pcbh_t_data) & txfer & st.t_write;
    if (st.chk_data & mism) begin
      next_st.perr_seen = 1'b1;
      if (i_command[`PCBH_CMD_PERR_BIT]) begin
        next_st.perr_n = 1'b0;
        next_st.perr_oe = 1'b1;
      end
    end
    next_st.serr_oe = (i_command[`PCBH_CMD_SERR_BIT] & ((st.chk_addr & mism) | i_sys_err)) |
                      (i_cb_serr_en & i_cb_addr_perr);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus.dev_frame_n = st.frame_n;
  assign bus.dev_irdy_n = st.irdy_n;
  assign bus.dev_ictl_oe = st.ictl_oe;
  assign bus.dev_devsel_n = st.devsel_n;
  assign bus.dev_trdy_n = st.trdy_n;
  assign bus.dev_stop_n = st.stop_n;
  assign bus.dev_tctl_oe = st.tctl_oe;
  assign bus.dev_ad = st.ad;
  assign bus.dev_ad_oe = st.ad_oe;
  assign bus.dev_cbe = st.cbe;
  assign bus.dev_cbe_oe = st.cbe_oe;
  assign bus.dev_par = st.par;
  assign bus.dev_par_oe = st.par_oe;
  assign bus.dev_perr_n = st.perr_n;
  assign bus.dev_perr_oe = st.perr_oe;
  assign bus.dev_serr_oe = st.serr_oe;
  assign bus.dev_req_n = st.req_n;
  assign o_busy = st.busy;
  assign o_done = st.done;
  assign o_abort = st.abort;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_twvalid = st.twvalid;
  assign o_twdata = st.memreg;
  assign o_perr_seen = st.perr_seen;
endmodule

// >>> hw/pcbh_if.sv
// Shared bus wires of the control handshake, resolved from each party's drives.
`timescale 1ns/1ps
interface pcbh_if;
  logic dev_frame_n, dev_irdy_n, dev_ictl_oe, dev_devsel_n, dev_trdy_n, dev_stop_n, dev_tctl_oe;
  logic [31:0] dev_ad;
  logic [3:0] dev_cbe;
  logic dev_ad_oe, dev_cbe_oe, dev_par, dev_par_oe, dev_perr_n, dev_perr_oe, dev_serr_oe;
  logic dev_req_n;
  logic peer_frame_n, peer_irdy_n, peer_ictl_oe, peer_devsel_n, peer_trdy_n, peer_stop_n;
  logic peer_tctl_oe;
  logic [31:0] peer_ad;
  logic [3:0] peer_cbe;
  logic peer_ad_oe, peer_cbe_oe, peer_par, peer_par_oe, peer_gnt_n, peer_idsel;
  logic frame_n, irdy_n, devsel_n, trdy_n, stop_n, perr_n, serr_n, par;
  logic [31:0] ad;
  logic [3:0] cbe;
  logic req_n, gnt_n, idsel;
  // Undriven control lines float high through their pull-ups.
  assign frame_n = dev_ictl_oe ? dev_frame_n : (peer_ictl_oe ? peer_frame_n : 1'b1);
  assign irdy_n = dev_ictl_oe ? dev_irdy_n : (peer_ictl_oe ? peer_irdy_n : 1'b1);
  assign devsel_n = dev_tctl_oe ? dev_devsel_n : (peer_tctl_oe ? peer_devsel_n : 1'b1);
  assign trdy_n = dev_tctl_oe ? dev_trdy_n : (peer_tctl_oe ? peer_trdy_n : 1'b1);
  assign stop_n = dev_tctl_oe ? dev_stop_n : (peer_tctl_oe ? peer_stop_n : 1'b1);
  assign ad = dev_ad_oe ? dev_ad : (peer_ad_oe ? peer_ad : 32'h0);
  assign cbe = dev_cbe_oe ? dev_cbe : (peer_cbe_oe ? peer_cbe : 4'hf);
  assign par = dev_par_oe ? dev_par : (peer_par_oe ? peer_par : 1'b0);
  assign perr_n = dev_perr_oe ? dev_perr_n : 1'b1;
  assign serr_n = ~dev_serr_oe;
  assign req_n = dev_req_n;
  assign gnt_n = peer_gnt_n;
  assign idsel = peer_idsel;
  modport dev_mp (
    output dev_frame_n, dev_irdy_n, dev_ictl_oe, dev_devsel_n, dev_trdy_n, dev_stop_n,
    output dev_tctl_oe, dev_ad, dev_cbe, dev_ad_oe, dev_cbe_oe, dev_par, dev_par_oe,
    output dev_perr_n, dev_perr_oe, dev_serr_oe, dev_req_n,
    input frame_n, irdy_n, devsel_n, trdy_n, stop_n, ad, cbe, par, gnt_n, idsel
  );
  modport peer_mp (
    output peer_frame_n, peer_irdy_n, peer_ictl_oe, peer_devsel_n, peer_trdy_n, peer_stop_n,
    output peer_tctl_oe, peer_ad, peer_cbe, peer_ad_oe, peer_cbe_oe, peer_par, peer_par_oe,
    output peer_gnt_n, peer_idsel,
    input frame_n, irdy_n, devsel_n, trdy_n, stop_n, ad, cbe, par, req_n, perr_n, serr_n
  );
endinterface

// >>> hw/pcbh_map.svh
// Bus commands, bit positions, address windows and timing counts of the control handshake.
`ifndef PCBH_MAP_SVH
`define PCBH_MAP_SVH
`define PCBH_CMD_MEMRD 4'h6
`define PCBH_CMD_MEMWR 4'h7
`define PCBH_CMD_CFGRD 4'ha
`define PCBH_CMD_CFGWR 4'hb
`define PCBH_CMD_PERR_BIT 6
`define PCBH_CMD_SERR_BIT 8
`define PCBH_DEVSEL_TMO 4'h5
`define PCBH_DEV_BASE 32'h1000_0000
`define PCBH_DEV_MASK 32'hffff_f000
`define PCBH_PEER_BASE 32'h2000_0000
`define PCBH_PEER_MASK 32'hffff_f000
`endif

// >>> hw/pcbh_peer.sv
// Far end of the control handshake: arbiter, single-phase initiator and memory target.
`timescale 1ns/1ps
`include "pcbh_map.svh"
module pcbh_peer #(
  parameter logic [31:0] BASE = `PCBH_PEER_BASE,
  parameter logic [31:0] MASK = `PCBH_PEER_MASK,
  parameter logic [3:0] TIMEOUT = `PCBH_DEVSEL_TMO
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Bus side.
  pcbh_if.peer_mp bus,
  // Arbiter control.
  input wire logic i_park,
  // Initiator requests and answers.
  input wire logic i_start,
  input wire logic i_write,
  input wire logic i_cfg,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic o_abort,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  // Target side.
  input wire logic i_wait,
  input wire logic i_stop,
  output logic o_wvalid,
  output logic [31:0] o_wdata
);
  localparam pcbh_pkg::pcbh_peer_st_t RST = '{
    pst: pcbh_pkg::pcbh_i_idle,
    qst: pcbh_pkg::pcbh_t_idle,
    gnt_n: 1'b1,
    frame_n: 1'b1,
    irdy_n: 1'b1,
    devsel_n: 1'b1,
    trdy_n: 1'b1,
    stop_n: 1'b1,
    frame_prev_n: 1'b1,
    default: '0
  };
  pcbh_pkg::pcbh_peer_st_t st, next_st;
  logic idle_bus, ixfer, txfer, timeout, addr_phase, hit;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.abort = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.wvalid = 1'b0;
    idle_bus = bus.frame_n & bus.irdy_n;
    ixfer = ~st.irdy_n & ~bus.trdy_n;
    txfer = ~bus.irdy_n & ~st.trdy_n;
    timeout = ~st.got_dev & bus.devsel_n & (st.tcnt == TIMEOUT - 4'h1);
    addr_phase = ~bus.frame_n & st.frame_prev_n & (st.pst != pcbh_pkg::pcbh_i_addr);
    hit = ((bus.cbe == `PCBH_CMD_MEMRD) | (bus.cbe == `PCBH_CMD_MEMWR)) &
          ((bus.ad & MASK) == BASE);
    next_st.gnt_n = ~((~bus.req_n | i_park) & (st.pst == pcbh_pkg::pcbh_i_idle) & ~i_start);
    case (st.pst)
      pcbh_pkg::pcbh_i_idle: begin
        if (i_start & st.gnt_n & idle_bus & (st.qst == pcbh_pkg::pcbh_t_idle)) begin
          next_st.pst = pcbh_pkg::pcbh_i_addr;
          next_st.busy = 1'b1;
          next_st.frame_n = 1'b0;
          next_st.ictl_oe = 1'b1;
          next_st.ad = i_addr;
          next_st.ad_oe = 1'b1;
          next_st.cbe = i_cfg ? (i_write ? `PCBH_CMD_CFGWR : `PCBH_CMD_CFGRD)
                              : (i_write ? `PCBH_CMD_MEMWR : `PCBH_CMD_MEMRD);
          next_st.cbe_oe = 1'b1;
          next_st.idsel = i_cfg;
          next_st.iwrite = i_write;
          next_st.iwdata = i_wdata;
        end
      end
      pcbh_pkg::pcbh_i_addr: begin
        next_st.pst = pcbh_pkg::pcbh_i_data;
        next_st.frame_n = 1'b1;
        next_st.irdy_n = 1'b0;
        next_st.ad = st.iwdata;
        next_st.ad_oe = st.iwrite;
        next_st.cbe = 4'h0;
        next_st.idsel = 1'b0;
        next_st.tcnt = 4'h0;
        next_st.got_dev = 1'b0;
      end
      pcbh_pkg::pcbh_i_data: begin
        if (~bus.devsel_n) begin
          next_st.got_dev = 1'b1;
        end else if (~st.got_dev) begin
          next_st.tcnt = st.tcnt + 4'h1;
        end
        if (ixfer | ~bus.stop_n | timeout) begin
          next_st.pst = pcbh_pkg::pcbh_i_turn;
          next_st.irdy_n = 1'b1;
          next_st.ad_oe = 1'b0;
          next_st.cbe_oe = 1'b0;
          next_st.done = ~timeout | ixfer;
          next_st.abort = timeout & ~ixfer;
          next_st.rvalid = ixfer & ~st.iwrite;
          next_st.rdata = bus.ad;
        end
      end
      pcbh_pkg::pcbh_i_turn: begin
        next_st.ictl_oe = 1'b0;
        next_st.busy = 1'b0;
        next_st.pst = pcbh_pkg::pcbh_i_idle;
      end
      default: begin
        next_st.pst = pcbh_pkg::pcbh_i_idle;
      end
    endcase
    case (st.qst)
      pcbh_pkg::pcbh_t_idle: begin
        if (addr_phase & hit) begin
          next_st.qst = pcbh_pkg::pcbh_t_claim;
          next_st.devsel_n = 1'b0;
          next_st.trdy_n = 1'b1;
          next_st.stop_n = 1'b1;
          next_st.tctl_oe = 1'b1;
          next_st.t_write = bus.cbe[0];
        end
      end
      pcbh_pkg::pcbh_t_claim: begin
        next_st.qst = pcbh_pkg::pcbh_t_data;
        next_st.trdy_n = i_wait;
        next_st.stop_n = ~i_stop;
        if (~st.t_write) begin
          next_st.ad = st.mem;
          next_st.ad_oe = 1'b1;
        end
      end
      pcbh_pkg::pcbh_t_data: begin
        if (txfer & st.t_write) begin
          next_st.mem = bus.ad;
          next_st.wvalid = 1'b1;
        end
        next_st.stop_n = st.stop_n & ~i_stop;
        if (bus.frame_n & (txfer | ~st.stop_n)) begin
          next_st.qst = pcbh_pkg::pcbh_t_turn;
          next_st.devsel_n = 1'b1;
          next_st.trdy_n = 1'b1;
          next_st.stop_n = 1'b1;
          next_st.ad_oe = 1'b0;
        end else if (~st.stop_n) begin
          next_st.trdy_n = st.trdy_n | txfer;
        end else begin
          next_st.trdy_n = i_wait;
        end
      end
      pcbh_pkg::pcbh_t_turn: begin
        next_st.tctl_oe = 1'b0;
        next_st.qst = pcbh_pkg::pcbh_t_idle;
      end
      default: begin
        next_st.qst = pcbh_pkg::pcbh_t_idle;
      end
    endcase
    next_st.frame_prev_n = bus.frame_n;
    next_st.par = pcbh_pkg::pcbh_parity(bus.ad, bus.cbe);
    next_st.par_oe = st.ad_oe;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus.peer_frame_n = st.frame_n;
  assign bus.peer_irdy_n = st.irdy_n;
  assign bus.peer_ictl_oe = st.ictl_oe;
  assign bus.peer_devsel_n = st.devsel_n;
  assign bus.peer_trdy_n = st.trdy_n;
  assign bus.peer_stop_n = st.stop_n;
  assign bus.peer_tctl_oe = st.tctl_oe;
  assign bus.peer_ad = st.ad;
  assign bus.peer_ad_oe = st.ad_oe;
  assign bus.peer_cbe = st.cbe;
  assign bus.peer_cbe_oe = st.cbe_oe;
  assign bus.peer_par = st.par;
  assign bus.peer_par_oe = st.par_oe;
  assign bus.peer_gnt_n = st.gnt_n;
  assign bus.peer_idsel = st.idsel;
  assign o_busy = st.busy;
  assign o_done = st.done;
  assign o_abort = st.abort;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_wvalid = st.wvalid;
  assign o_wdata = st.mem;
endmodule

// >>> hw/pcbh_pkg.sv
// Types and the parity function shared by both ends of the control handshake.
package pcbh_pkg;
  typedef enum logic [2:0] {
    pcbh_i_idle = 3'h0,
    pcbh_i_req = 3'h1,
    pcbh_i_addr = 3'h3,
    pcbh_i_data = 3'h2,
    pcbh_i_turn = 3'h6
  } pcbh_ist_t;
  typedef enum logic [1:0] {
    pcbh_t_idle = 2'h0,
    pcbh_t_claim = 2'h1,
    pcbh_t_data = 2'h3,
    pcbh_t_turn = 2'h2
  } pcbh_tst_t;
  typedef struct packed {
    pcbh_ist_t ist;
    pcbh_tst_t tst;
    logic req_n, frame_n, irdy_n, ictl_oe, devsel_n, trdy_n, stop_n, tctl_oe;
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe;
    logic cbe_oe, par, par_oe, perr_n, perr_oe, serr_oe;
    logic [3:0] icmd;
    logic [31:0] iaddr, iwdata;
    logic [3:0] ibe;
    logic [7:0] remain;
    logic [3:0] tcnt;
    logic got_dev, abort_pend, busy, done, abort, rvalid;
    logic [31:0] rdata, memreg, cfgreg;
    logic twvalid, t_write, t_cfg, frame_prev_n, chk_data, chk_addr, perr_seen;
  } pcbh_dev_st_t;
  typedef struct packed {
    pcbh_ist_t pst;
    pcbh_tst_t qst;
    logic gnt_n, idsel, frame_n, irdy_n, ictl_oe, devsel_n, trdy_n, stop_n, tctl_oe;
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe;
    logic cbe_oe, par, par_oe, iwrite;
    logic [31:0] iwdata;
    logic [3:0] tcnt;
    logic got_dev, busy, done, abort, rvalid;
    logic [31:0] rdata, mem;
    logic wvalid, t_write, frame_prev_n;
  } pcbh_peer_st_t;
  function automatic logic pcbh_parity(input logic [31:0] ad, input logic [3:0] cbe);
    return ^{ad, cbe};
  endfunction
endpackage
